// ==== i2c_flag_pkg.sv ====
package i2c_flag_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_MASK     = 8'h04;
  localparam logic [7:0] OFS_INT_VEC  = 8'h08;
  localparam logic [7:0] OFS_TX_DATA  = 8'h0c;
  localparam logic [7:0] OFS_RX_DATA  = 8'h10;
  localparam logic [7:0] OFS_MODE     = 8'h14;

  // ----------------------------------------------------------------
  // status and mask field positions
  // ----------------------------------------------------------------
  localparam int BIT_GCALL    = 8;
  localparam int BIT_STOP     = 5;
  localparam int BIT_TX_RDY   = 4;
  localparam int BIT_RX_RDY   = 3;
  localparam int BIT_REGS_RDY = 2;
  localparam logic [31:0] STATUS_USED = 32'h0000013c;

  // ----------------------------------------------------------------
  // mode register fields and reset values
  // ----------------------------------------------------------------
  localparam int BIT_RUN    = 0;
  localparam int BIT_MASTER = 1;
  localparam logic [1:0]  MODE_RST   = 2'h0;
  localparam logic [31:0] MASK_RST   = 32'h00000000;
  localparam logic [7:0]  DATA_RST   = 8'h00;

  // ----------------------------------------------------------------
  // interrupt codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_REGS = 3'h3;
  localparam logic [2:0] CODE_RX   = 3'h4;
  localparam logic [2:0] CODE_TX   = 3'h5;
  localparam logic [2:0] CODE_STOP = 3'h6;

  localparam int SYNC_W = 2;

  typedef struct packed {
    logic gcall;
    logic tx_load;
    logic rx_load;
    logic regs_done;
    logic regs_start;
  } engine_evt_t;

  typedef struct packed {
    logic        gcall;
    logic        stop;
    logic        tx_rdy;
    logic        rx_rdy;
    logic        regs_rdy;
  } flags_t;

endpackage

// ==== pin_sync.sv ====
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  // idle bus level is high on both lines
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          stage1_reg[g] <= 1'b1;
          stage2_reg[g] <= 1'b1;
        end else begin
          stage1_reg[g] <= async_i[g];
          stage2_reg[g] <= stage1_reg[g];
        end
      end
    end
  endgenerate

  assign sync_o = stage2_reg;
endmodule // pin_sync

// ==== i2c_status_flags.sv ====
`timescale 1ns/100ps
// Summary of operation
// - general call flag, bit 8, sets on an all-zero received address
// - general call flag clears on any start or stop on the bus
// - status bits 7-6 read zero and ignore writes
// - stop seen flag, bit 5, sets on any stop, from anyone
// - stop seen flag clears when interrupt vector read returns code 110b
// - writing one clears stop seen flag; zero leaves it
// - tx ready flag, bit 4, sets when tx data moves to shifter
// - tx ready flag clears when software writes tx data register
// - writing one clears tx ready flag
// - tx ready flag is forced to one while controller is in reset
// - rx ready flag, bit 3, sets when word lands in rx data register
// - rx ready clears on rx data read, processor reset, run bit zero
// - writing one clears rx ready flag
// - regs ready flag sets, master mode only, when registers consumed
// - regs ready flag clears when controller starts using registers
// - tx, rx, regs ready flags pollable and drive interrupt requests
// - writing one clears regs ready flag
module i2c_status_flags
  import i2c_flag_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_N_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // bus pins, sampled only
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  // serial engine
  input  wire engine_evt_t ENGINE_EVT_I,
  input  wire logic [7:0]  RX_WORD_I,
  output logic      [7:0]  TX_DATA_O,
  output logic             MODULE_RUN_O,
  output logic             MASTER_MODE_O,
  // interrupt requests
  output logic             TX_READY_IRQ_O,
  output logic             RX_READY_IRQ_O,
  output logic             REGS_READY_IRQ_O,
  output logic             INT_O
);

  // ----------------------------------------------------------------
  // pin synchronisers and start/stop detection
  // ----------------------------------------------------------------
  logic [1:0] pins_s;
  logic       sda_prev_reg;
  logic       sda_prev_next;
  logic       start_det;
  logic       stop_det;

  pin_sync #(.W(SYNC_W)) u_pin_sync (
    .clk_i     (CLK_SYS_I),
    .reset_n_i (RESET_N_I),
    .async_i   ({SCL_I, SDA_I}),
    .sync_o    (pins_s)
  );

  // data changing while the clock line is high marks start or stop
  always_comb begin
    sda_prev_next = pins_s[0];
    start_det     = pins_s[1] & sda_prev_reg & ~pins_s[0];
    stop_det      = pins_s[1] & ~sda_prev_reg & pins_s[0];
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sda_prev_reg <= 1'b1;
    end else begin
      sda_prev_reg <= sda_prev_next;
    end
  end

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  // one wait state lets read data come from a flop
  logic        pready_reg;
  logic        pready_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        acc_done;
  logic        wr_done;
  logic        rd_done;
  flags_t      flags_reg;
  flags_t      flags_next;
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic [1:0]  mode_reg;
  logic [1:0]  mode_next;
  logic [7:0]  tx_data_reg;
  logic [7:0]  tx_data_next;
  logic [7:0]  rx_data_reg;
  logic [7:0]  rx_data_next;
  logic [2:0]  int_code;
  logic [31:0] status_word;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == OFS_STATUS) || (a == OFS_MASK) ||
                 (a == OFS_INT_VEC) || (a == OFS_TX_DATA) ||
                 (a == OFS_RX_DATA) || (a == OFS_MODE);
  endfunction

  function automatic logic [31:0] pack_flags(input flags_t f);
    pack_flags = 32'h0;
    pack_flags[BIT_GCALL]    = f.gcall;
    pack_flags[BIT_STOP]     = f.stop;
    pack_flags[BIT_TX_RDY]   = f.tx_rdy;
    pack_flags[BIT_RX_RDY]   = f.rx_rdy;
    pack_flags[BIT_REGS_RDY] = f.regs_rdy;
  endfunction

  always_comb begin
    acc_done     = PSEL_I & PENABLE_I & pready_reg;
    wr_done      = acc_done & PWRITE_I & addr_known(PADDR_I);
    rd_done      = acc_done & ~PWRITE_I;
    pready_next  = PSEL_I & PENABLE_I & ~pready_reg;
    pslverr_next = pready_next & ~addr_known(PADDR_I);
    prdata_next  = prdata_reg;
    if (pready_next && !PWRITE_I) begin
      case (PADDR_I)
        OFS_STATUS:  prdata_next = status_word;
        OFS_MASK:    prdata_next = mask_reg & STATUS_USED;
        OFS_INT_VEC: prdata_next = {29'h0, int_code};
        OFS_TX_DATA: prdata_next = {24'h0, tx_data_reg};
        OFS_RX_DATA: prdata_next = {24'h0, rx_data_reg};
        OFS_MODE:    prdata_next = {30'h0, mode_reg};
        default:     prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ----------------------------------------------------------------
  // interrupt code
  // ----------------------------------------------------------------
  // fixed priority among enabled pending flags except general call, stop highest
  always_comb begin
    status_word = pack_flags(flags_reg);
    int_code    = CODE_NONE;
    if (flags_reg.regs_rdy && mask_reg[BIT_REGS_RDY]) int_code = CODE_REGS;
    if (flags_reg.rx_rdy && mask_reg[BIT_RX_RDY])     int_code = CODE_RX;
    if (flags_reg.tx_rdy && mask_reg[BIT_TX_RDY])     int_code = CODE_TX;
    if (flags_reg.stop && mask_reg[BIT_STOP])         int_code = CODE_STOP;
  end

  // ----------------------------------------------------------------
  // configuration and data registers
  // ----------------------------------------------------------------
  logic w1c_stop;
  logic w1c_tx;
  logic w1c_rx;
  logic w1c_regs;
  logic tx_wr;
  logic rx_rd;
  logic vec_stop_rd;
  logic run;

  always_comb begin
    mask_next    = mask_reg;
    mode_next    = mode_reg;
    tx_data_next = tx_data_reg;
    rx_data_next = rx_data_reg;
    if (wr_done && PADDR_I == OFS_MASK)    mask_next = PWDATA_I & STATUS_USED;
    if (wr_done && PADDR_I == OFS_MODE)    mode_next = PWDATA_I[1:0];
    if (wr_done && PADDR_I == OFS_TX_DATA) tx_data_next = PWDATA_I[7:0];
    if (ENGINE_EVT_I.rx_load)              rx_data_next = RX_WORD_I;
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mask_reg    <= MASK_RST;
      mode_reg    <= MODE_RST;
      tx_data_reg <= DATA_RST;
      rx_data_reg <= DATA_RST;
    end else begin
      mask_reg    <= mask_next;
      mode_reg    <= mode_next;
      tx_data_reg <= tx_data_next;
      rx_data_reg <= rx_data_next;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_comb begin
    run         = mode_reg[BIT_RUN];
    w1c_stop    = wr_done && PADDR_I == OFS_STATUS && PWDATA_I[BIT_STOP];
    w1c_tx      = wr_done && PADDR_I == OFS_STATUS && PWDATA_I[BIT_TX_RDY];
    w1c_rx      = wr_done && PADDR_I == OFS_STATUS && PWDATA_I[BIT_RX_RDY];
    w1c_regs    = wr_done && PADDR_I == OFS_STATUS &&
                  PWDATA_I[BIT_REGS_RDY];
    tx_wr       = wr_done && PADDR_I == OFS_TX_DATA;
    rx_rd       = rd_done && PADDR_I == OFS_RX_DATA;
    vec_stop_rd = rd_done && PADDR_I == OFS_INT_VEC &&
                  prdata_reg[2:0] == CODE_STOP;
    // set term is or-ed last so a same-cycle event is kept, except rx ready, where run zero gates the set term too
    flags_next.gcall = ENGINE_EVT_I.gcall |
                       (flags_reg.gcall & ~start_det & ~stop_det);
    flags_next.stop  = stop_det |
                       (flags_reg.stop & ~vec_stop_rd &
                        ~w1c_stop);
    flags_next.tx_rdy = ~run | ENGINE_EVT_I.tx_load |
                        (flags_reg.tx_rdy & ~tx_wr &
                         ~w1c_tx);
    flags_next.rx_rdy = run & (ENGINE_EVT_I.rx_load |
                        (flags_reg.rx_rdy & ~rx_rd &
                         ~w1c_rx));
    flags_next.regs_rdy = (ENGINE_EVT_I.regs_done &
                           mode_reg[BIT_MASTER]) |
                          (flags_reg.regs_rdy &
                           ~ENGINE_EVT_I.regs_start &
                           ~w1c_regs);
  end

  // tx ready reads one from reset because the controller starts held
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      flags_reg <= '{gcall: 1'b0, stop: 1'b0, tx_rdy: 1'b1,
                     rx_rdy: 1'b0, regs_rdy: 1'b0};
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [31:0] status_next;
  logic        int_reg;
  logic        int_next;
  logic [2:0]  irq_reg;
  logic [2:0]  irq_next;

  always_comb begin
    status_next = pack_flags(flags_next);
    int_next    = |(status_next & mask_next);
    irq_next    = {status_next[BIT_TX_RDY] & mask_next[BIT_TX_RDY],
                   status_next[BIT_RX_RDY] & mask_next[BIT_RX_RDY],
                   status_next[BIT_REGS_RDY] & mask_next[BIT_REGS_RDY]};
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      int_reg <= 1'b0;
      irq_reg <= 3'h0;
    end else begin
      int_reg <= int_next;
      irq_reg <= irq_next;
    end
  end

  assign PRDATA_O         = prdata_reg;
  assign PREADY_O         = pready_reg;
  assign PSLVERR_O        = pslverr_reg;
  assign TX_DATA_O        = tx_data_reg;
  assign MODULE_RUN_O     = mode_reg[BIT_RUN];
  assign MASTER_MODE_O    = mode_reg[BIT_MASTER];
  assign TX_READY_IRQ_O   = irq_reg[2];
  assign RX_READY_IRQ_O   = irq_reg[1];
  assign REGS_READY_IRQ_O = irq_reg[0];
  assign INT_O            = int_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);

  property p_gcall_set;
    ENGINE_EVT_I.gcall |=> flags_reg.gcall;
  endproperty
  a_gcall_set: assert property (p_gcall_set)
    else $error("general call flag not set");

  property p_gcall_clr;
    (start_det || stop_det) && !ENGINE_EVT_I.gcall |=> !flags_reg.gcall;
  endproperty
  a_gcall_clr: assert property (p_gcall_clr)
    else $error("general call flag not cleared by start or stop");

  property p_reserved;
    pready_reg && $past(PADDR_I) == OFS_STATUS |-> prdata_reg[7:6] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits read nonzero");

  property p_stop_set;
    stop_det |=> flags_reg.stop;
  endproperty
  a_stop_set: assert property (p_stop_set)
    else $error("stop seen flag not set");

  property p_stop_vec_clr;
    vec_stop_rd && !stop_det |=> !flags_reg.stop;
  endproperty
  a_stop_vec_clr: assert property (p_stop_vec_clr)
    else $error("stop flag survived vector read of stop code");

  property p_stop_hold;
    flags_reg.stop && !w1c_stop && !vec_stop_rd |=> flags_reg.stop;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop flag lost without a clear");

  property p_tx_clr;
    (tx_wr || w1c_tx) && run && !ENGINE_EVT_I.tx_load
      ##1 mode_reg[BIT_RUN] |-> !flags_reg.tx_rdy;
  endproperty
  a_tx_clr: assert property (p_tx_clr)
    else $error("tx ready not cleared");

  property p_tx_forced;
    !mode_reg[BIT_RUN] |=> flags_reg.tx_rdy[*2];
  endproperty
  a_tx_forced: assert property (p_tx_forced)
    else $error("tx ready not forced while held in reset");

  property p_rx_flow;
    ENGINE_EVT_I.rx_load && run ##1 mode_reg[BIT_RUN]
      |-> flags_reg.rx_rdy && rx_data_reg == $past(RX_WORD_I);
  endproperty
  a_rx_flow: assert property (p_rx_flow)
    else $error("rx ready or rx data wrong after load");

  property p_rx_clr;
    (rx_rd || w1c_rx || !run) && !ENGINE_EVT_I.rx_load
      |=> !flags_reg.rx_rdy;
  endproperty
  a_rx_clr: assert property (p_rx_clr)
    else $error("rx ready not cleared");

  property p_regs_slave;
    !flags_reg.regs_rdy && !mode_reg[BIT_MASTER] |=> !flags_reg.regs_rdy;
  endproperty
  a_regs_slave: assert property (p_regs_slave)
    else $error("regs ready set outside master mode");

  property p_regs_clr;
    (ENGINE_EVT_I.regs_start || w1c_regs) && !ENGINE_EVT_I.regs_done
      |=> !flags_reg.regs_rdy;
  endproperty
  a_regs_clr: assert property (p_regs_clr)
    else $error("regs ready not cleared");

  property p_irq;
    ##1 TX_READY_IRQ_O == (flags_reg.tx_rdy && mask_reg[BIT_TX_RDY]) &&
        INT_O == |(status_word & mask_reg);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt outputs disagree with flags and mask");

  c_stop_vec:  cover property (stop_det ##[1:200] vec_stop_rd);
  c_tx_cycle:  cover property (tx_wr ##[1:200] ENGINE_EVT_I.tx_load);
  c_rx_read:   cover property (ENGINE_EVT_I.rx_load ##[1:200] rx_rd);
  c_set_wins:  cover property (stop_det && w1c_stop);

endmodule // i2c_status_flags

// ==== i2c_bus_peer.sv ====
`timescale 1ns/100ps
module i2c_bus_peer (
  // released bus lines sit at the pull-up level
  output logic scl_o,
  output logic sda_o
);
  localparam int HALF_NS = 400;

  // link clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // ----------------------------------------------------------------
  // frame pieces
  // ----------------------------------------------------------------
  // data bits only move while the clock is low, so no false conditions
  // pin moves may land on a system clock edge, so they go non-blocking
  task automatic start_hold(input int nbits);
    int i;
    sda_o <= 1'b0;
    #HALF_NS scl_o <= 1'b0;
    for (i = 0; i < nbits; i++) begin
      #(HALF_NS/2) sda_o <= 1'($urandom);
      #(HALF_NS/2) scl_o <= 1'b1;
      #HALF_NS scl_o <= 1'b0;
    end
  endtask

  task automatic stop_bus();
    #(HALF_NS/2) sda_o <= 1'b0;
    #(HALF_NS/2) scl_o <= 1'b1;
    #HALF_NS sda_o <= 1'b1;
    #HALF_NS;
  endtask
endmodule // i2c_bus_peer

// ==== i2c_status_flag_logic_tb_top.sv ====
`timescale 1ns/100ps
module i2c_status_flag_logic_tb_top;
  import i2c_flag_pkg::*;
  localparam engine_evt_t EV_GC   = 5'h10;
  localparam engine_evt_t EV_TX   = 5'h08;
  localparam engine_evt_t EV_RX   = 5'h04;
  localparam engine_evt_t EV_DONE = 5'h02;
  localparam engine_evt_t EV_BEG  = 5'h01;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        scl, sda, run, master, tx_irq, rx_irq, regs_irq, intr;
  logic [7:0]  paddr, rx_word, tx_data, w;
  logic [31:0] pwdata, prdata, rd, m;
  engine_evt_t evt;
  int          err_count, comparisons;

  i2c_status_flags dut_u (
    .CLK_SYS_I        (clk),
    .RESET_N_I        (rst_n),
    .PSEL_I           (psel),
    .PENABLE_I        (penable),
    .PWRITE_I         (pwrite),
    .PADDR_I          (paddr),
    .PWDATA_I         (pwdata),
    .PRDATA_O         (prdata),
    .PREADY_O         (pready),
    .PSLVERR_O        (pslverr),
    .SCL_I            (scl),
    .SDA_I            (sda),
    .ENGINE_EVT_I     (evt),
    .RX_WORD_I        (rx_word),
    .TX_DATA_O        (tx_data),
    .MODULE_RUN_O     (run),
    .MASTER_MODE_O    (master),
    .TX_READY_IRQ_O   (tx_irq),
    .RX_READY_IRQ_O   (rx_irq),
    .REGS_READY_IRQ_O (regs_irq),
    .INT_O            (intr)
  );

  i2c_bus_peer peer_u (
    .scl_o (scl),
    .sda_o (sda)
  );

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ev rides in the cycle before the completing edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input engine_evt_t ev);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (n == 0) evt <= ev;
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, 32'(pready));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    evt <= '0;
  endtask

  // registered outputs take the write on the edge it lands; wait one more edge to sample them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0);
    @(posedge clk);
  endtask

  // expected vector code: stop before tx before rx before regs
  function automatic logic [2:0] exp_code(input logic [31:0] s, mk);
    logic [31:0] p;
    p = s & mk;
    if (p[BIT_STOP]) return CODE_STOP;
    if (p[BIT_TX_RDY]) return CODE_TX;
    if (p[BIT_RX_RDY]) return CODE_RX;
    if (p[BIT_REGS_RDY]) return CODE_REGS;
    return CODE_NONE;
  endfunction

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0, '0);
    chk(nm, e, rd);
  endtask

  task automatic stbit(input string nm, input int b, input logic e);
    apb(1'b0, OFS_STATUS, 32'h0, '0);
    chk(nm, 32'(e), 32'(rd[b]));
  endtask

  task automatic pulse(input engine_evt_t ev, input logic [7:0] d);
    @(posedge clk);
    evt <= ev;
    rx_word <= d;
    @(posedge clk);
    evt <= '0;
  endtask

  task automatic final_report();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // a hang cuts the run short; tests need well under 2000 cycles
  initial begin
    #1000000;
    err_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    evt = '0;
    rx_word = 8'h00;
    err_count = 0;
    comparisons = 0;
    void'($urandom(26159));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("status", OFS_STATUS, 32'h00000010);
    rdc("mask", OFS_MASK, MASK_RST);
    apb(1'b0, 8'h18, 32'h0, '0);
    chk("slverr", 32'h1, 32'(err));
    chk("unmapped", 32'h0, rd);
    wr(OFS_MASK, 32'hffffffff);
    rdc("mask", OFS_MASK, STATUS_USED);
    wr(OFS_MODE, 32'h00000003);
    chk("run", 32'h1, 32'(run));
    chk("master", 32'h1, 32'(master));
    // transmit flag
    w = 8'($urandom);
    wr(OFS_TX_DATA, 32'(w));
    chk("tx data", 32'(w), 32'(tx_data));
    stbit("tx rdy", BIT_TX_RDY, 1'b0);
    pulse(EV_TX, w);
    stbit("tx rdy", BIT_TX_RDY, 1'b1);
    wr(OFS_STATUS, 32'h00000010);
    stbit("tx rdy", BIT_TX_RDY, 1'b0);
    apb(1'b1, OFS_STATUS, 32'h00000010, EV_TX);
    stbit("tx rdy", BIT_TX_RDY, 1'b1);
    wr(OFS_STATUS, 32'h000000c0);
    rdc("status", OFS_STATUS, 32'h00000010);
    // receive flag
    w = 8'($urandom);
    pulse(EV_RX, w);
    stbit("rx rdy", BIT_RX_RDY, 1'b1);
    chk("rx irq", 32'h1, 32'(rx_irq));
    rdc("rx data", OFS_RX_DATA, 32'(w));
    stbit("rx rdy", BIT_RX_RDY, 1'b0);
    pulse(EV_RX, w);
    wr(OFS_STATUS, 32'h00000008);
    stbit("rx rdy", BIT_RX_RDY, 1'b0);
    pulse(EV_RX, w);
    apb(1'b1, OFS_STATUS, 32'h00000008, EV_RX);
    stbit("rx rdy", BIT_RX_RDY, 1'b1);
    wr(OFS_MODE, 32'h00000000);
    stbit("rx rdy", BIT_RX_RDY, 1'b0);
    wr(OFS_STATUS, 32'h00000010);
    stbit("tx rdy", BIT_TX_RDY, 1'b1);
    pulse(EV_RX, w);
    stbit("rx rdy", BIT_RX_RDY, 1'b0);
    wr(OFS_MODE, 32'h00000003);
    // register access flag
    pulse(EV_DONE, w);
    stbit("regs rdy", BIT_REGS_RDY, 1'b1);
    pulse(EV_BEG, w);
    stbit("regs rdy", BIT_REGS_RDY, 1'b0);
    pulse(EV_DONE, w);
    wr(OFS_STATUS, 32'h00000004);
    stbit("regs rdy", BIT_REGS_RDY, 1'b0);
    wr(OFS_MODE, 32'h00000001);
    pulse(EV_DONE, w);
    stbit("regs rdy", BIT_REGS_RDY, 1'b0);
    wr(OFS_MODE, 32'h00000003);
    // requests and vector code under a random mask, then one bit each
    pulse(EV_TX | EV_RX | EV_DONE, w);
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? ($urandom & 32'h0000001c) : (32'h00000002 << i);
      wr(OFS_MASK, m);
      chk("tx irq", 32'(m[4]), 32'(tx_irq));
      chk("rx irq", 32'(m[3]), 32'(rx_irq));
      chk("regs irq", 32'(m[2]), 32'(regs_irq));
      chk("int", 32'(|m), 32'(intr));
      rdc("vector", OFS_INT_VEC, 32'(exp_code(32'h0000001c, m)));
    end
    wr(OFS_STATUS, 32'h0000013c);
    // general call and bus conditions
    pulse(EV_GC, w);
    stbit("gcall", BIT_GCALL, 1'b1);
    peer_u.start_hold(2);
    repeat (8) @(posedge clk);
    stbit("gcall", BIT_GCALL, 1'b0);
    pulse(EV_GC, w);
    peer_u.stop_bus();
    repeat (8) @(posedge clk);
    stbit("gcall", BIT_GCALL, 1'b0);
    stbit("stop", BIT_STOP, 1'b1);
    wr(OFS_STATUS, 32'h00000000);
    stbit("stop", BIT_STOP, 1'b1);
    pulse(EV_TX, w);
    wr(OFS_MASK, 32'h00000010);
    rdc("vector", OFS_INT_VEC, 32'(CODE_TX));
    stbit("stop", BIT_STOP, 1'b1);
    wr(OFS_MASK, 32'h00000020);
    rdc("vector", OFS_INT_VEC, 32'(CODE_STOP));
    stbit("stop", BIT_STOP, 1'b0);
    peer_u.start_hold(3);
    peer_u.stop_bus();
    repeat (8) @(posedge clk);
    stbit("stop", BIT_STOP, 1'b1);
    wr(OFS_STATUS, 32'h00000020);
    stbit("stop", BIT_STOP, 1'b0);
    // processor reset in mid-run drops rx ready and restores defaults
    pulse(EV_RX, w);
    stbit("rx rdy", BIT_RX_RDY, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("run", 32'h0, 32'(run));
    rdc("status", OFS_STATUS, 32'h00000010);
    rdc("mask", OFS_MASK, MASK_RST);
    final_report();
  end
endmodule // i2c_status_flag_logic_tb_top
